// File: rtl/rio_supervision.sv
// remote i/o supervision: presence check, access watchdog, inputs, mirrors
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module rio_supervision #(
   parameter int TICK100_CYC = rio_pkg::TICK100_CYC,
   parameter int NUM_IN = rio_pkg::NUM_IN,
   parameter int NUM_MIR = rio_pkg::NUM_MIR
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NUM_IN-1:0] rawIn,
   input wire rio_pkg::rio_iocnt_t physCount,
   input wire rio_pkg::rio_frame_t frameIn,
   input wire rio_pkg::rio_msg_t msgIn,
   output logic [NUM_IN-1:0] doutPins,
   output logic okLed,
   output logic frameLocal,
   output logic frameFwd,
   output rio_pkg::rio_stat_t statusOut
);
   function automatic logic isMirror(input logic [11:0] a);
      return (a >= rio_pkg::A_MIR) && (a < rio_pkg::A_MIR_END);
   endfunction

   function automatic logic [7:0] mirIdx(input logic [11:0] a);
      logic [11:0] off;
      off = a - rio_pkg::A_MIR;
      return off[9:2];
   endfunction

   rio_pkg::rio_ctrl_t ctrl_q;
   rio_pkg::rio_iocnt_t exp_q;
   rio_pkg::rio_dly_t dly_q [NUM_IN];
   rio_pkg::rio_stat_t statusOut_q;
   logic [15:0] wdt_q;
   logic [15:0] wdCnt_q;
   logic [NUM_IN-1:0] cntMode_q;
   logic [NUM_IN-1:0] dout_q;
   logic [NUM_IN-1:0] doutPins_q;
   logic [NUM_IN-1:0] din;
   logic [NUM_IN-1:0] dinPrev_q;
   logic [NUM_IN-1:0] cntWr;
   logic [15:0] cnt [NUM_IN];
   logic [15:0] mirror_q [NUM_MIR];
   logic [15:0] last_q [NUM_MIR];
   logic [3:0] monEn_q;
   logic [7:0] ownAddr_q;
   logic [31:0] div_q;
   logic [3:0] secDiv_q;
   logic [31:0] prdata_q;
   logic [31:0] rd;
   logic tick100_q;
   logic tickSec_q;
   logic ioErr_q;
   logic restart_q;
   logic mismatch;
   logic wdFire;
   logic pready_q;
   logic pslverr_q;
   logic okLed_q;
   logic frameLocal_q;
   logic frameFwd_q;
   logic pend_q;
   logic rdErr;
   logic wrEn;
   logic rdPhase;
   logic mirWr;
   logic [7:0] wIdx;

   // tick dividers
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         div_q <= 32'h0;
         secDiv_q <= 4'h0;
         tick100_q <= 1'b0;
         tickSec_q <= 1'b0;
      end else begin
         tick100_q <= 1'b0;
         tickSec_q <= 1'b0;
         if (div_q == 32'(TICK100_CYC - 1)) begin
            div_q <= 32'h0;
            tick100_q <= 1'b1;
            if (secDiv_q == rio_pkg::TICKS_PER_SEC - 4'h1) begin
               secDiv_q <= 4'h0;
               tickSec_q <= 1'b1;
            end else begin
               secDiv_q <= secDiv_q + 4'h1;
            end
         end else begin
            div_q <= div_q + 32'h1;
         end
      end
   end

   // input channels
   genvar gi;
   generate
      for (gi = 0; gi < NUM_IN; gi++) begin : g_in
         rio_input_chan u_chan (
            .sys_clk(sys_clk),
            .rstn(rstn),
            .tick100(tick100_q),
            .tickSec(tickSec_q),
            .rawIn(rawIn[gi]),
            .timerMode(cntMode_q[gi]),
            .dlyCfg(dly_q[gi]),
            .cntWr(cntWr[gi]),
            .cntWdata(pwdata[15:0]),
            .level(din[gi]),
            .count(cnt[gi])
         );
         assign cntWr[gi] = wrEn && (paddr[11:6] == rio_pkg::A_CNT[11:6])
                            && (paddr[5:2] == 4'(gi));
      end
   endgenerate

   // apb: one wait state, write lands on the edge that sees pready
   assign rdPhase = psel && penable && !pready_q;
   assign wrEn = psel && penable && pready_q && pwrite && !pslverr_q;
   assign mirWr = wrEn && isMirror(paddr);
   assign wIdx = mirIdx(paddr);

   always_comb begin
      rd = 32'h0;
      rdErr = 1'b0;
      case (paddr)
         rio_pkg::A_CTRL: rd = {28'h0, ctrl_q};
         rio_pkg::A_STATUS: begin
            rd[rio_pkg::ST_RESTART] = restart_q;
            rd[rio_pkg::ST_IOERR] = ioErr_q;
            rd[rio_pkg::ST_OK] = !ioErr_q;
         end
         rio_pkg::A_WDT: rd = {16'h0, wdt_q};
         rio_pkg::A_CNTMODE: rd = {16'h0, cntMode_q};
         rio_pkg::A_DIN: rd = {16'h0, din};
         rio_pkg::A_DOUT: rd = {16'h0, dout_q};
         rio_pkg::A_MONEN: rd = {28'h0, monEn_q};
         rio_pkg::A_OWNADDR: rd = {24'h0, ownAddr_q};
         rio_pkg::A_EXP0: rd = {exp_q[1], exp_q[0]};
         rio_pkg::A_EXP1: rd = {exp_q[3], exp_q[2]};
         rio_pkg::A_PHYS0: rd = {physCount[1], physCount[0]};
         rio_pkg::A_PHYS1: rd = {physCount[3], physCount[2]};
         default: begin
            if (isMirror(paddr)) begin
               rd = {16'h0, mirror_q[mirIdx(paddr)]};
            end else if (paddr[11:6] == rio_pkg::A_DLY[11:6]) begin
               rd = {22'h0, dly_q[paddr[5:2]]};
            end else if (paddr[11:6] == rio_pkg::A_CNT[11:6]) begin
               rd = {16'h0, cnt[paddr[5:2]]};
            end else begin
               rdErr = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= rdPhase;
         if (rdPhase) begin
            pslverr_q <= rdErr;
            prdata_q <= pwrite ? 32'h0 : rd;
         end else begin
            pslverr_q <= 1'b0;
         end
      end
   end

   // configuration registers
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= rio_pkg::CTRL_RST;
         wdt_q <= rio_pkg::WDT_RST;
         cntMode_q <= rio_pkg::CNTMODE_RST;
         monEn_q <= 4'h0;
         ownAddr_q <= rio_pkg::OWNADDR_RST;
         exp_q <= '0;
         for (int i = 0; i < NUM_IN; i++) begin
            dly_q[i] <= '0;
         end
      end else if (wrEn) begin
         case (paddr)
            rio_pkg::A_CTRL: ctrl_q <= pwdata[3:0];
            rio_pkg::A_WDT: wdt_q <= pwdata[15:0];
            rio_pkg::A_CNTMODE: cntMode_q <= pwdata[15:0];
            rio_pkg::A_MONEN: monEn_q <= pwdata[3:0];
            rio_pkg::A_OWNADDR: ownAddr_q <= pwdata[7:0];
            rio_pkg::A_EXP0: exp_q[1:0] <= pwdata;
            rio_pkg::A_EXP1: exp_q[3:2] <= pwdata;
            default: begin
               if (paddr[11:6] == rio_pkg::A_DLY[11:6]) begin
                  dly_q[paddr[5:2]] <= pwdata[9:0];
               end
            end
         endcase
      end
   end

   // presence supervision
   always_comb begin
      mismatch = 1'b0;
      for (int t = 0; t < rio_pkg::NUM_TYPES; t++) begin
         if (monEn_q[t] && exp_q[t] != physCount[t]) begin
            mismatch = 1'b1;
         end
      end
   end

   // a live mismatch beats the software clear
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ioErr_q <= 1'b0;
         restart_q <= 1'b1;
      end else begin
         if (mismatch) begin
            ioErr_q <= 1'b1;
         end else if (wrEn && paddr == rio_pkg::A_STATUS
                      && pwdata[rio_pkg::ST_IOERR]) begin
            ioErr_q <= 1'b0;
         end
         if (wrEn && paddr == rio_pkg::A_STATUS && pwdata[rio_pkg::ST_RESTART]) begin
            restart_q <= 1'b0;
         end
      end
   end

   // access watchdog in seconds; a zero timeout loaded by a frame never fires
   assign wdFire = tickSec_q && !frameIn.valid && wdCnt_q == 16'h0001;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wdCnt_q <= rio_pkg::WDT_RST;
      end else if (frameIn.valid) begin
         wdCnt_q <= wdt_q;
      end else if (tickSec_q && wdCnt_q != 16'h0000) begin
         wdCnt_q <= wdCnt_q - 16'h0001;
      end
   end

   // outputs: expiry wipes the setpoints, a mismatch only masks them
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         dout_q <= '0;
         doutPins_q <= '0;
         okLed_q <= 1'b0;
      end else begin
         if (wdFire && ctrl_q.wdEn) begin
            dout_q <= '0;
         end else if (wrEn && paddr == rio_pkg::A_DOUT) begin
            dout_q <= pwdata[NUM_IN-1:0];
         end
         doutPins_q <= ioErr_q ? '0 : dout_q;
         if (!ioErr_q) begin
            okLed_q <= 1'b1;
         end else if (tick100_q) begin
            okLed_q <= !okLed_q;
         end
      end
   end

   // modbus frame steering, one-cycle pulses
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         frameLocal_q <= 1'b0;
         frameFwd_q <= 1'b0;
      end else begin
         frameLocal_q <= frameIn.valid && ctrl_q.modbusEn
                         && frameIn.addr == ownAddr_q;
         frameFwd_q <= frameIn.valid && ctrl_q.modbusEn && ctrl_q.masterMode
                       && frameIn.addr != ownAddr_q;
      end
   end

   // outstation status messages, held back to the second tick
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         dinPrev_q <= '0;
         pend_q <= 1'b0;
         statusOut_q <= '0;
      end else begin
         dinPrev_q <= din;
         statusOut_q.valid <= 1'b0;
         if (ctrl_q.unsolEn && !ctrl_q.masterMode && din != dinPrev_q) begin
            pend_q <= 1'b1;
         end else if (tickSec_q && pend_q) begin
            pend_q <= 1'b0;
         end
         if (tickSec_q && pend_q) begin
            statusOut_q.valid <= 1'b1;
            statusOut_q.data <= din;
         end
      end
   end

   // slave mirrors; a fresh rising input wins over a same-cycle clear
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NUM_MIR; i++) begin
            mirror_q[i] <= 16'h0000;
            last_q[i] <= 16'h0000;
         end
      end else begin
         if (mirWr) begin
            mirror_q[wIdx] <= pwdata[15:0];
         end
         if (msgIn.valid && ctrl_q.masterMode && msgIn.station < 8'(NUM_MIR)) begin
            mirror_q[msgIn.station] <= ((mirWr && wIdx == msgIn.station)
               ? pwdata[15:0] : mirror_q[msgIn.station])
               | (msgIn.inputs & ~last_q[msgIn.station]);
            last_q[msgIn.station] <= msgIn.inputs;
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign doutPins = doutPins_q;
   assign okLed = okLed_q;
   assign frameLocal = frameLocal_q;
   assign frameFwd = frameFwd_q;
   assign statusOut = statusOut_q;
endmodule

// File: rtl/rio_pkg.sv
// constants and types shared by the remote i/o supervision block
package rio_pkg;
   localparam int NUM_IN = 16;
   localparam int NUM_MIR = 240;
   localparam int NUM_TYPES = 4;
   localparam int CLK_HZ = 20_000_000;
   localparam int TICK_MS = 100;
   localparam int TICK100_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam logic [3:0] TICKS_PER_SEC = 4'ha;
   localparam logic [11:0] A_CTRL = 12'h000;
   localparam logic [11:0] A_STATUS = 12'h004;
   localparam logic [11:0] A_WDT = 12'h008;
   localparam logic [11:0] A_CNTMODE = 12'h00c;
   localparam logic [11:0] A_DIN = 12'h010;
   localparam logic [11:0] A_DOUT = 12'h014;
   localparam logic [11:0] A_MONEN = 12'h018;
   localparam logic [11:0] A_OWNADDR = 12'h01c;
   localparam logic [11:0] A_EXP0 = 12'h020;
   localparam logic [11:0] A_EXP1 = 12'h024;
   localparam logic [11:0] A_PHYS0 = 12'h028;
   localparam logic [11:0] A_PHYS1 = 12'h02c;
   localparam logic [11:0] A_DLY = 12'h040;
   localparam logic [11:0] A_CNT = 12'h080;
   localparam logic [11:0] A_MIR = 12'h400;
   localparam logic [11:0] A_MIR_END = 12'h7c0;
   localparam int ST_RESTART = 7;
   localparam int ST_IOERR = 6;
   localparam int ST_OK = 3;
   localparam logic [15:0] CNTMODE_RST = 16'hff00;
   localparam logic [15:0] WDT_RST = 16'h003c;
   localparam logic [7:0] OWNADDR_RST = 8'h01;
   localparam logic [1:0] DLY_OFF = 2'h0;
   localparam logic [1:0] DLY_ON = 2'h1;
   localparam logic [1:0] DLY_BOTH = 2'h2;
   typedef struct packed {
      logic masterMode;
      logic modbusEn;
      logic unsolEn;
      logic wdEn;
   } rio_ctrl_t;
   typedef struct packed {
      logic [1:0] mode;
      logic [7:0] val;
   } rio_dly_t;
   typedef struct packed {
      logic valid;
      logic [7:0] addr;
   } rio_frame_t;
   typedef struct packed {
      logic valid;
      logic [7:0] station;
      logic [15:0] inputs;
   } rio_msg_t;
   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } rio_stat_t;
   typedef logic [NUM_TYPES-1:0][15:0] rio_iocnt_t;
   localparam rio_ctrl_t CTRL_RST = 4'h0;
endpackage

// File: rtl/rio_input_chan.sv
// one embedded input: on/off delay filter plus event counter or low-time timer
`timescale 1ns/1ps
module rio_input_chan (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic tick100,
   input wire logic tickSec,
   input wire logic rawIn,
   input wire logic timerMode,
   input wire rio_pkg::rio_dly_t dlyCfg,
   input wire logic cntWr,
   input wire logic [15:0] cntWdata,
   output logic level,
   output logic [15:0] count
);
   logic level_q;
   logic prev_q;
   logic [7:0] dly_q;
   logic [15:0] count_q;
   logic useDly;

   // rising edge is the on-delay, falling edge the off-delay
   assign useDly = rawIn ? (dlyCfg.mode != rio_pkg::DLY_OFF)
                         : (dlyCfg.mode == rio_pkg::DLY_BOTH);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         level_q <= 1'b0;
         dly_q <= 8'h00;
      end else if (rawIn == level_q) begin
         dly_q <= 8'h00;
      end else if (!useDly || dly_q >= dlyCfg.val) begin
         level_q <= rawIn;
         dly_q <= 8'h00;
      end else if (tick100) begin
         dly_q <= dly_q + 8'h01;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prev_q <= 1'b0;
         count_q <= 16'h0000;
      end else begin
         prev_q <= level_q;
         if (cntWr) begin
            count_q <= cntWdata;
         end else if (!timerMode && level_q && !prev_q) begin
            count_q <= count_q + 16'h0001;
         end else if (timerMode && tickSec && !level_q) begin
            count_q <= count_q + 16'h0001;
         end
      end
   end

   assign level = level_q;
   assign count = count_q;
endmodule

// File: verification/rio_supervision_asserts.sv
// port-level assertion checker for the supervision block
`timescale 1ns/1ps
module rio_supervision_asserts #(
   parameter int NUM_IN = rio_pkg::NUM_IN,
   parameter int TICK100_CYC = rio_pkg::TICK100_CYC
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire rio_pkg::rio_frame_t frameIn,
   input wire logic frameLocal,
   input wire logic frameFwd,
   input wire logic [NUM_IN-1:0] doutPins,
   input wire logic okLed,
   input wire rio_pkg::rio_stat_t statusOut
);
   localparam int SEC_CYC = 10 * TICK100_CYC;
   logic [31:0] gap_q;
   // saturated at all ones so the first report after reset is legal at any tick rate
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         gap_q <= 32'hffffffff;
      end else if (statusOut.valid) begin
         gap_q <= 32'h0;
      end else if (gap_q != 32'hffffffff) begin
         gap_q <= gap_q + 32'h1;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   AST_APB_WAIT: assert property (psel && !penable ##1 psel && penable
      |-> !pready ##1 pready)
      else $error("apb answer not after one wait state");
   AST_READY_GAP: assert property (pready |=> !pready [*2])
      else $error("pready too soon after previous answer");
   AST_READY_REQ: assert property (pready |-> psel && penable && $past(penable))
      else $error("pready without a pending access");
   AST_ERR_READY: assert property (pslverr |-> pready)
      else $error("pslverr outside an answer");
   AST_LOCAL_CAUSE: assert property (frameLocal |-> $past(frameIn.valid))
      else $error("local frame pulse without a frame");
   AST_FWD_CAUSE: assert property (frameFwd |-> $past(frameIn.valid) && !frameLocal)
      else $error("forward pulse without a foreign frame");
   AST_ERR_OUT_OFF: assert property ($fell(okLed) |-> doutPins == '0)
      else $error("outputs on while ok lamp flashes");
   AST_STAT_SPACING: assert property (statusOut.valid |-> gap_q >= SEC_CYC - 1)
      else $error("status reports closer than one second");
endmodule

bind rio_supervision rio_supervision_asserts #(.NUM_IN(NUM_IN), .TICK100_CYC(TICK100_CYC)) u_chk (
   .sys_clk(sys_clk),
   .rstn(rstn),
   .psel(psel),
   .penable(penable),
   .pready(pready),
   .pslverr(pslverr),
   .frameIn(frameIn),
   .frameLocal(frameLocal),
   .frameFwd(frameFwd),
   .doutPins(doutPins),
   .okLed(okLed),
   .statusOut(statusOut)
);

// File: verification/rio_poll_master.sv
// polling master and remote stations: frames and change messages
`timescale 1ns/1ps
module rio_poll_master #(
   parameter int TICK100_CYC = 5
) (
   input wire logic sys_clk,
   input wire logic frameLocal,
   input wire logic frameFwd,
   output rio_pkg::rio_frame_t frameIn,
   output rio_pkg::rio_msg_t msgIn
);
   initial begin
      frameIn = '0;
      msgIn = '0;
   end
   task automatic send_frame(input logic [7:0] a, output logic loc, output logic fwd);
      @(posedge sys_clk);
      frameIn <= '{valid: 1'b1, addr: a};
      @(posedge sys_clk);
      frameIn <= '0;
      #1;
      loc = frameLocal;
      fwd = frameFwd;
   endtask
   task automatic send_msg(input logic [7:0] st, input logic [15:0] d);
      // a station never reports twice within one second
      repeat (10 * TICK100_CYC) @(posedge sys_clk);
      msgIn <= '{valid: 1'b1, station: st, inputs: d};
      @(posedge sys_clk);
      msgIn <= '0;
      @(posedge sys_clk);
   endtask
endmodule

// File: verification/rio_supervision_bench.sv
// self-checking bench for the supervision block
`timescale 1ns/1ps
module rio_supervision_bench;
   localparam int TK = 5;
   localparam int SEC = 10 * TK;
   logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, okLed;
   logic frameLocal, frameFwd, err, loc, fwd, sawLow;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] rawIn, doutPins, lastStat;
   rio_pkg::rio_iocnt_t physCount;
   rio_pkg::rio_frame_t frameIn;
   rio_pkg::rio_msg_t msgIn;
   rio_pkg::rio_stat_t statusOut;
   int n_mismatch, num_checks;
   logic [11:0] rAddr [7] = '{rio_pkg::A_CTRL, rio_pkg::A_STATUS, rio_pkg::A_WDT,
      rio_pkg::A_CNTMODE, rio_pkg::A_OWNADDR, rio_pkg::A_DOUT, rio_pkg::A_DLY};
   logic [31:0] rExp [7] = '{32'h0, 32'h88, 32'h3c, 32'hff00, 32'h1, 32'h0, 32'h0};
   rio_supervision #(.TICK100_CYC(TK)) dut (
      .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rawIn(rawIn), .physCount(physCount), .frameIn(frameIn), .msgIn(msgIn),
      .doutPins(doutPins), .okLed(okLed), .frameLocal(frameLocal), .frameFwd(frameFwd),
      .statusOut(statusOut));
   rio_poll_master #(.TICK100_CYC(TK)) pm (
      .sys_clk(sys_clk), .frameLocal(frameLocal), .frameFwd(frameFwd),
      .frameIn(frameIn), .msgIn(msgIn));
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         lastStat <= 16'h0;
      end else if (statusOut.valid === 1'b1) begin
         lastStat <= statusOut.data;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(rd, e);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      finish_test();
   end
   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      rawIn = 16'hff00;
      physCount = '0;
      physCount[0] = 16'h0010;
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      foreach (rAddr[i]) rdc(rAddr[i], rExp[i]);
      apb(1'b0, 12'h300, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      $display("test registers done");
      wr(rio_pkg::A_DOUT, 32'hff);
      wr(rio_pkg::A_EXP0, 32'h8);
      wr(rio_pkg::A_MONEN, 32'h1);
      rdc(rio_pkg::A_STATUS, 32'hc0);
      check({16'h0, doutPins}, 32'h0);
      sawLow = 1'b0;
      repeat (2 * TK + 2) begin
         @(posedge sys_clk);
         if (okLed === 1'b0) sawLow = 1'b1;
      end
      check({31'h0, sawLow}, 32'h1);
      wr(rio_pkg::A_STATUS, 32'h40);
      rdc(rio_pkg::A_STATUS, 32'hc0);
      wr(rio_pkg::A_EXP0, 32'h10);
      wr(rio_pkg::A_STATUS, 32'hc0);
      rdc(rio_pkg::A_STATUS, 32'h08);
      check({16'h0, doutPins}, 32'hff);
      $display("test presence done");
      wr(rio_pkg::A_WDT, 32'h2);
      wr(rio_pkg::A_CTRL, 32'h1);
      repeat (8) begin
         pm.send_frame(8'h7, loc, fwd);
         repeat (SEC / 2) @(posedge sys_clk);
      end
      check({16'h0, doutPins}, 32'hff);
      repeat (3 * SEC) @(posedge sys_clk);
      check({16'h0, doutPins}, 32'h0);
      wr(rio_pkg::A_CTRL, 32'h0);
      wr(rio_pkg::A_DOUT, 32'hf);
      // reload so the count really runs out while the watchdog is off
      pm.send_frame(8'h7, loc, fwd);
      repeat (3 * SEC) @(posedge sys_clk);
      check({16'h0, doutPins}, 32'hf);
      $display("test watchdog done");
      wr(rio_pkg::A_CTRL, 32'hc);
      pm.send_frame(8'h1, loc, fwd);
      check({30'h0, loc, fwd}, 32'h2);
      pm.send_frame(8'h22, loc, fwd);
      check({30'h0, loc, fwd}, 32'h1);
      pm.send_msg(8'h3, 16'h1);
      rdc(rio_pkg::A_MIR + 12'hc, 32'h1);
      pm.send_msg(8'h3, 16'h3);
      rdc(rio_pkg::A_MIR + 12'hc, 32'h3);
      wr(rio_pkg::A_MIR + 12'hc, 32'h0);
      pm.send_msg(8'h3, 16'h3);
      rdc(rio_pkg::A_MIR + 12'hc, 32'h0);
      pm.send_msg(8'h3, 16'h0);
      pm.send_msg(8'h3, 16'h8000);
      rdc(rio_pkg::A_MIR + 12'hc, 32'h8000);
      pm.send_msg(8'hef, 16'h10);
      rdc(rio_pkg::A_MIR + 12'h3bc, 32'h10);
      wr(rio_pkg::A_MIR + 12'h4, 32'h1234);
      rdc(rio_pkg::A_MIR + 12'h4, 32'h1234);
      wr(rio_pkg::A_CTRL, 32'h4);
      pm.send_frame(8'h22, loc, fwd);
      check({30'h0, loc, fwd}, 32'h0);
      $display("test frames and mirrors done");
      wr(rio_pkg::A_CTRL, 32'h2);
      wr(rio_pkg::A_DLY, 32'h103);
      wr(rio_pkg::A_DLY + 12'h8, 32'h203);
      rawIn[0] <= 1'b1;
      rawIn[2] <= 1'b1;
      rdc(rio_pkg::A_DIN, 32'hff00);
      repeat (5 * TK) @(posedge sys_clk);
      rdc(rio_pkg::A_DIN, 32'hff05);
      repeat (SEC + 5) @(posedge sys_clk);
      check({16'h0, lastStat}, 32'hff05);
      rawIn[0] <= 1'b0;
      rawIn[2] <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rdc(rio_pkg::A_DIN, 32'hff04);
      repeat (5 * TK) @(posedge sys_clk);
      rdc(rio_pkg::A_DIN, 32'hff00);
      repeat (SEC + 5) @(posedge sys_clk);
      check({16'h0, lastStat}, 32'hff00);
      wr(rio_pkg::A_CNT + 12'h4, 32'h0);
      repeat (3) begin
         rawIn[1] <= 1'b1;
         repeat (4) @(posedge sys_clk);
         rawIn[1] <= 1'b0;
         repeat (4) @(posedge sys_clk);
      end
      rdc(rio_pkg::A_CNT + 12'h4, 32'h3);
      wr(rio_pkg::A_CNT + 12'h20, 32'h0);
      rawIn[8] <= 1'b0;
      repeat (3 * SEC) @(posedge sys_clk);
      rawIn[8] <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rdc(rio_pkg::A_CNT + 12'h20, 32'h3);
      $display("test inputs done");
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      rdc(rio_pkg::A_STATUS, 32'h88);
      $display("test second reset done");
      finish_test();
   end
endmodule
